// *** logic/mmhr_pkg.sv ***
package mmhr_pkg;

    localparam logic [15:0] OFS_MEASURED   = 16'h0001;
    localparam logic [15:0] OFS_STATUS     = 16'h0002;
    localparam logic [15:0] OFS_DP         = 16'h0003;
    localparam logic [15:0] OFS_RELAY      = 16'h0004;
    localparam logic [15:0] OFS_CURRENT    = 16'h0005;
    localparam logic [15:0] OFS_PEAK       = 16'h0006;
    localparam logic [15:0] OFS_RANGE      = 16'h0010;
    localparam logic [15:0] OFS_CHAR       = 16'h0011;
    localparam logic [15:0] OFS_FILTER     = 16'h0012;
    localparam logic [15:0] OFS_DP_MIRROR  = 16'h0013;
    localparam logic [15:0] OFS_SCALE_LO   = 16'h0014;
    localparam logic [15:0] OFS_SCALE_HI   = 16'h0015;
    localparam logic [15:0] OFS_EXT_LO     = 16'h0016;
    localparam logic [15:0] OFS_EXT_HI     = 16'h0017;
    localparam logic [15:0] OFS_STATION    = 16'h0020;
    localparam logic [15:0] OFS_IDENT      = 16'h0021;
    localparam logic [15:0] OFS_BIT_RATE   = 16'h0022;
    localparam logic [15:0] OFS_PERMIT     = 16'h0023;
    localparam logic [15:0] OFS_SECURITY   = 16'h0024;

    localparam logic [7:0]  FN_READ        = 8'h03;
    localparam logic [7:0]  FN_WRITE_ONE   = 8'h06;
    localparam logic [7:0]  FN_WRITE_GROUP = 8'h10;
    localparam logic [7:0]  GROUP_MAX      = 8'h10;
    localparam logic [7:0]  BROADCAST      = 8'h00;

    localparam logic [7:0]  EXC_NONE       = 8'h00;
    localparam logic [7:0]  EXC_FUNCTION   = 8'h01;
    localparam logic [7:0]  EXC_ADDRESS    = 8'h02;
    localparam logic [7:0]  EXC_VALUE      = 8'h03;

    localparam logic [15:0] STAT_VALID     = 16'h0000;
    localparam logic [15:0] STAT_OVER      = 16'h00a0;
    localparam logic [15:0] STAT_UNDER     = 16'h0060;

    localparam logic [15:0] SIGNED_MIN     = 16'hfc19;
    localparam logic [15:0] SIGNED_MAX     = 16'h270f;
    localparam logic [15:0] MAX_DP         = 16'h0003;
    localparam logic [15:0] MAX_RANGE      = 16'h0005;
    localparam logic [15:0] MAX_CHAR       = 16'h0003;
    localparam logic [15:0] MAX_FILTER     = 16'h0005;
    localparam logic [15:0] MAX_CURRENT    = 16'h1800;
    localparam logic [15:0] MAX_EXT_LO     = 16'h03e7;
    localparam logic [15:0] MAX_EXT_HI     = 16'h00c7;
    localparam logic [15:0] MAX_STATION    = 16'h00c7;
    localparam logic [15:0] MAX_BIT_RATE   = 16'h0007;
    localparam logic [15:0] MAX_PERMIT     = 16'h0001;
    localparam logic [15:0] MAX_SECURITY   = 16'h000f;
    localparam logic [15:0] ANY_VALUE      = 16'hffff;

    localparam logic [7:0]  RST_STATION    = 8'h01;
    localparam logic [2:0]  RST_BIT_RATE   = 3'h3;
    localparam logic        RST_PERMIT     = 1'b1;

    // one register access, already cut out of the frame by the link layer
    typedef struct packed {
        logic [7:0]  station;
        logic [7:0]  func_code;
        logic [7:0]  count;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mmhr_req_s;

    typedef struct packed {
        logic        silent;
        logic [7:0]  exc;
        logic [15:0] rdata;
    } mmhr_rsp_s;

    typedef struct packed {
        logic [2:0]  input_range;
        logic [1:0]  characteristic;
        logic [2:0]  filter_rate;
        logic [1:0]  decimal_point;
        logic [15:0] scale_low_value;
        logic [15:0] scale_high_value;
        logic [9:0]  range_extension_low;
        logic [7:0]  range_extension_high;
        logic [7:0]  station_address;
        logic [2:0]  bit_rate_select;
        logic        remote_write_permit;
        logic [3:0]  security_flags;
    } mmhr_cfg_s;

endpackage

// *** logic/mmhr_bank.sv ***
`timescale 1ns/1ps
module mmhr_bank #(
    // arbitrary value, not a real part code
    parameter logic [15:0] IDENT_CODE = 16'h5a5a
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // register access from the frame layer
    input  wire logic               req_valid,
    input  wire mmhr_pkg::mmhr_req_s req,
    output logic                    req_ready_q,
    // answer to the frame layer
    output logic                    rsp_valid_q,
    output mmhr_pkg::mmhr_rsp_s     rsp_q,
    // measurement side
    input  wire logic [15:0]        meas_value,
    input  wire logic               meas_over,
    input  wire logic               meas_under,
    input  wire logic [15:0]        peak_value,
    input  wire logic               alarm_led,
    // front panel
    input  wire logic               panel_permit_set,
    input  wire logic               panel_permit_clr,
    // controlled outputs
    output logic [3:0]              relays_q,
    output logic [15:0]             current_out_q,
    output mmhr_pkg::mmhr_cfg_s     cfg_q
);

    typedef enum logic [1:0] {
        MMHR_IDLE   = 2'b01,
        MMHR_ANSWER = 2'b10
    } mmhr_state_e;

    mmhr_state_e         st_q, st_d;
    logic                ready_d, rsp_valid_d;
    mmhr_pkg::mmhr_rsp_s rsp_d;
    mmhr_pkg::mmhr_cfg_s cfg_d;
    logic [3:0]          relays_d;
    logic [15:0]         current_d;
    logic [15:0]         meas_q, peak_q, status_q, status_d;
    logic                led_q;
    logic [16:0]         rd;
    logic [7:0]          exc;
    logic                take, addressed, is_read, is_write;

    // signed bounds compare as two's complement
    function automatic logic signed_ok(input logic [15:0] v);
        return ($signed(v) >= $signed(mmhr_pkg::SIGNED_MIN)) && ($signed(v) <= $signed(mmhr_pkg::SIGNED_MAX));
    endfunction

    // returns {hit, data}
    function automatic logic [16:0] read_reg(
        input logic [15:0]         addr,
        input mmhr_pkg::mmhr_cfg_s c,
        input logic [3:0]          rel,
        input logic                led,
        input logic [15:0]         cur,
        input logic [15:0]         meas,
        input logic [15:0]         stat,
        input logic [15:0]         peak
    );
        logic [15:0] d;
        logic        hit;
        d   = 16'h0000;
        hit = 1'b1;
        case (addr)
            mmhr_pkg::OFS_MEASURED:  d = meas;
            mmhr_pkg::OFS_STATUS:    d = stat;
            mmhr_pkg::OFS_DP,
            mmhr_pkg::OFS_DP_MIRROR: d = {14'h0000, c.decimal_point};
            mmhr_pkg::OFS_RELAY:     d = {11'h000, led, rel};
            mmhr_pkg::OFS_CURRENT:   d = cur;
            mmhr_pkg::OFS_PEAK:      d = peak;
            mmhr_pkg::OFS_RANGE:     d = {13'h0000, c.input_range};
            mmhr_pkg::OFS_CHAR:      d = {14'h0000, c.characteristic};
            mmhr_pkg::OFS_FILTER:    d = {13'h0000, c.filter_rate};
            mmhr_pkg::OFS_SCALE_LO:  d = c.scale_low_value;
            mmhr_pkg::OFS_SCALE_HI:  d = c.scale_high_value;
            mmhr_pkg::OFS_EXT_LO:    d = {6'h00, c.range_extension_low};
            mmhr_pkg::OFS_EXT_HI:    d = {8'h00, c.range_extension_high};
            mmhr_pkg::OFS_STATION:   d = {8'h00, c.station_address};
            mmhr_pkg::OFS_IDENT:     d = IDENT_CODE;
            mmhr_pkg::OFS_BIT_RATE:  d = {13'h0000, c.bit_rate_select};
            mmhr_pkg::OFS_PERMIT:    d = {15'h0000, c.remote_write_permit};
            mmhr_pkg::OFS_SECURITY:  d = {12'h000, c.security_flags};
            default:                 hit = 1'b0;
        endcase
        return {hit, d};
    endfunction

    // exception for a write, EXC_NONE when it may be stored
    function automatic logic [7:0] write_check(input logic [15:0] addr, input logic [15:0] v);
        logic [15:0] lim;
        logic        sgn;
        logic        known;
        lim   = mmhr_pkg::ANY_VALUE;
        sgn   = 1'b0;
        known = 1'b1;
        case (addr)
            mmhr_pkg::OFS_DP,
            mmhr_pkg::OFS_DP_MIRROR: lim = mmhr_pkg::MAX_DP;
            mmhr_pkg::OFS_RELAY:     lim = mmhr_pkg::ANY_VALUE;
            mmhr_pkg::OFS_CURRENT:   lim = mmhr_pkg::MAX_CURRENT;
            mmhr_pkg::OFS_RANGE:     lim = mmhr_pkg::MAX_RANGE;
            mmhr_pkg::OFS_CHAR:      lim = mmhr_pkg::MAX_CHAR;
            mmhr_pkg::OFS_FILTER:    lim = mmhr_pkg::MAX_FILTER;
            mmhr_pkg::OFS_SCALE_LO,
            mmhr_pkg::OFS_SCALE_HI:  sgn = 1'b1;
            mmhr_pkg::OFS_EXT_LO:    lim = mmhr_pkg::MAX_EXT_LO;
            mmhr_pkg::OFS_EXT_HI:    lim = mmhr_pkg::MAX_EXT_HI;
            mmhr_pkg::OFS_STATION:   lim = mmhr_pkg::MAX_STATION;
            mmhr_pkg::OFS_BIT_RATE:  lim = mmhr_pkg::MAX_BIT_RATE;
            mmhr_pkg::OFS_PERMIT:    lim = mmhr_pkg::MAX_PERMIT;
            mmhr_pkg::OFS_SECURITY:  lim = mmhr_pkg::MAX_SECURITY;
            default:                 known = 1'b0;
        endcase
        if (!known)
            return mmhr_pkg::EXC_ADDRESS;
        if (sgn)
            return signed_ok(v) ? mmhr_pkg::EXC_NONE : mmhr_pkg::EXC_VALUE;
        return (v <= lim) ? mmhr_pkg::EXC_NONE : mmhr_pkg::EXC_VALUE;
    endfunction

    assign take      = req_valid && req_ready_q;
    assign addressed = (req.station == cfg_q.station_address) || (req.station == mmhr_pkg::BROADCAST);
    assign is_read   = (req.func_code == mmhr_pkg::FN_READ);
    assign is_write  = (req.func_code == mmhr_pkg::FN_WRITE_ONE) || (req.func_code == mmhr_pkg::FN_WRITE_GROUP);

    // measurement side is sampled so every read sees a settled word
    always_comb
    begin
        if (meas_over)
            status_d = mmhr_pkg::STAT_OVER;
        else if (meas_under)
            status_d = mmhr_pkg::STAT_UNDER;
        else
            status_d = mmhr_pkg::STAT_VALID;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meas_q   <= 16'h0000;
            peak_q   <= 16'h0000;
            status_q <= mmhr_pkg::STAT_VALID;
            led_q    <= 1'b0;
        end
        else
        begin
            meas_q   <= meas_value;
            peak_q   <= peak_value;
            status_q <= status_d;
            led_q    <= alarm_led;
        end
    end

    always_comb
    begin
        st_d        = st_q;
        ready_d     = req_ready_q;
        rsp_valid_d = 1'b0;
        rsp_d       = rsp_q;
        cfg_d       = cfg_q;
        relays_d    = relays_q;
        current_d   = current_out_q;
        exc         = mmhr_pkg::EXC_NONE;
        rd          = read_reg(req.addr, cfg_q, relays_q, led_q, current_out_q, meas_q, status_q, peak_q);
        unique case (st_q)
            MMHR_IDLE:
            begin
                ready_d = 1'b1;
                if (take)
                begin
                    st_d        = MMHR_ANSWER;
                    ready_d     = 1'b0;
                    rsp_valid_d = 1'b1;
                    if (!is_read && !is_write)
                        exc = mmhr_pkg::EXC_FUNCTION;
                    else if (req.func_code != mmhr_pkg::FN_WRITE_ONE
                             && (req.count == 8'h00 || req.count > mmhr_pkg::GROUP_MAX))
                        exc = mmhr_pkg::EXC_VALUE;
                    else if (is_read)
                        exc = rd[16] ? mmhr_pkg::EXC_NONE : mmhr_pkg::EXC_ADDRESS;
                    else if (!cfg_q.remote_write_permit)
                        exc = mmhr_pkg::EXC_FUNCTION;
                    else
                        // refused writes leave the register alone
                        exc = write_check(req.addr, req.wdata);
                    // a foreign station neither acts nor answers
                    if (!addressed)
                        exc = mmhr_pkg::EXC_NONE;
                    if (addressed && is_write && exc == mmhr_pkg::EXC_NONE)
                    begin
                        unique case (req.addr)
                            mmhr_pkg::OFS_DP,
                            mmhr_pkg::OFS_DP_MIRROR: cfg_d.decimal_point = req.wdata[1:0];
                            mmhr_pkg::OFS_RELAY:     relays_d = req.wdata[3:0];
                            mmhr_pkg::OFS_CURRENT:   current_d = req.wdata;
                            mmhr_pkg::OFS_RANGE:     cfg_d.input_range = req.wdata[2:0];
                            mmhr_pkg::OFS_CHAR:      cfg_d.characteristic = req.wdata[1:0];
                            mmhr_pkg::OFS_FILTER:    cfg_d.filter_rate = req.wdata[2:0];
                            mmhr_pkg::OFS_SCALE_LO:  cfg_d.scale_low_value = req.wdata;
                            mmhr_pkg::OFS_SCALE_HI:  cfg_d.scale_high_value = req.wdata;
                            mmhr_pkg::OFS_EXT_LO:    cfg_d.range_extension_low = req.wdata[9:0];
                            mmhr_pkg::OFS_EXT_HI:    cfg_d.range_extension_high = req.wdata[7:0];
                            // new station takes effect from the next request
                            mmhr_pkg::OFS_STATION:   cfg_d.station_address = req.wdata[7:0];
                            mmhr_pkg::OFS_BIT_RATE:  cfg_d.bit_rate_select = req.wdata[2:0];
                            mmhr_pkg::OFS_PERMIT:    cfg_d.remote_write_permit = req.wdata[0];
                            mmhr_pkg::OFS_SECURITY:  cfg_d.security_flags = req.wdata[3:0];
                            default:                 cfg_d = cfg_q;
                        endcase
                    end
                    rsp_d.exc    = exc;
                    rsp_d.rdata  = (is_read && exc == mmhr_pkg::EXC_NONE) ? rd[15:0] : req.wdata;
                    rsp_d.silent = !addressed || (req.station == mmhr_pkg::BROADCAST);
                end
            end
            MMHR_ANSWER:
            begin
                st_d    = MMHR_IDLE;
                ready_d = 1'b1;
            end
            default:
            begin
                st_d    = MMHR_IDLE;
                ready_d = 1'b1;
            end
        endcase
        // panel wins over the link in the same cycle; set wins over clear
        if (panel_permit_clr)
            cfg_d.remote_write_permit = 1'b0;
        if (panel_permit_set)
            cfg_d.remote_write_permit = 1'b1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q          <= MMHR_IDLE;
            req_ready_q   <= 1'b1;
            rsp_valid_q   <= 1'b0;
            rsp_q         <= '0;
            relays_q      <= 4'h0;
            current_out_q <= 16'h0000;
            cfg_q         <= '0;
            cfg_q.station_address     <= mmhr_pkg::RST_STATION;
            cfg_q.bit_rate_select     <= mmhr_pkg::RST_BIT_RATE;
            cfg_q.remote_write_permit <= mmhr_pkg::RST_PERMIT;
        end
        else
        begin
            st_q          <= st_d;
            req_ready_q   <= ready_d;
            rsp_valid_q   <= rsp_valid_d;
            rsp_q         <= rsp_d;
            relays_q      <= relays_d;
            current_out_q <= current_d;
            cfg_q         <= cfg_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic own_take;
    assign own_take = take && (req.station == cfg_q.station_address);

    meas_read_a: assert property (own_take && is_read && req.count == 8'h01
        && req.addr == mmhr_pkg::OFS_MEASURED
        |=> rsp_valid_q && rsp_q.rdata == $past(meas_q) && rsp_q.exc == mmhr_pkg::EXC_NONE)
        else $error("measured value read wrong");
    status_code_a: assert property (meas_over |=> status_q == mmhr_pkg::STAT_OVER)
        else $error("over range status wrong");
    status_under_a: assert property (!meas_over && meas_under |=> status_q == mmhr_pkg::STAT_UNDER)
        else $error("under range status wrong");
    dp_mirror_a: assert property (own_take && req.func_code == mmhr_pkg::FN_WRITE_ONE
        && req.addr == mmhr_pkg::OFS_DP_MIRROR && cfg_q.remote_write_permit && req.wdata <= mmhr_pkg::MAX_DP
        |=> cfg_q.decimal_point == $past(req.wdata[1:0]))
        else $error("decimal point mirror not stored");
    relay_read_a: assert property (own_take && is_read && req.count == 8'h01
        && req.addr == mmhr_pkg::OFS_RELAY
        |=> rsp_q.rdata == {11'h000, $past(led_q), $past(relays_q)})
        else $error("relay state read wrong");
    relay_write_a: assert property (own_take && is_write && req.addr == mmhr_pkg::OFS_RELAY
        |=> rsp_q.exc != mmhr_pkg::EXC_NONE || relays_q == $past(req.wdata[3:0]))
        else $error("relay write not applied");
    current_limit_a: assert property (current_out_q <= mmhr_pkg::MAX_CURRENT)
        else $error("current output above limit");
    peak_read_a: assert property (own_take && is_read && req.count == 8'h01
        && req.addr == mmhr_pkg::OFS_PEAK
        |=> rsp_q.rdata == $past(peak_q) && rsp_q.exc == mmhr_pkg::EXC_NONE)
        else $error("peak value read wrong");
    ident_read_a: assert property (own_take && is_read && req.count == 8'h01
        && req.addr == mmhr_pkg::OFS_IDENT
        |=> rsp_q.rdata == IDENT_CODE)
        else $error("identification code wrong");
    permit_deny_a: assert property (own_take && is_write && !cfg_q.remote_write_permit
        && req.count == 8'h01
        |=> rsp_q.exc == mmhr_pkg::EXC_FUNCTION && $stable(relays_q) && $stable(current_out_q))
        else $error("write taken while denied");
    panel_permit_a: assert property (panel_permit_set |=> cfg_q.remote_write_permit)
        else $error("panel permit set lost");
    group_limit_a: assert property (own_take && is_read && req.count > mmhr_pkg::GROUP_MAX
        |=> rsp_q.exc == mmhr_pkg::EXC_VALUE)
        else $error("oversize group accepted");
    bcast_silent_a: assert property (take && req.station == mmhr_pkg::BROADCAST
        |=> rsp_valid_q && rsp_q.silent ##1 req_ready_q)
        else $error("broadcast answered");
    foreign_quiet_a: assert property (take && !addressed
        |=> rsp_q.silent && rsp_q.exc == mmhr_pkg::EXC_NONE && $stable(relays_q) && $stable(current_out_q))
        else $error("foreign station request acted on");
    ro_write_a: assert property (own_take && is_write && req.count == 8'h01
        && cfg_q.remote_write_permit && req.addr == mmhr_pkg::OFS_PEAK
        |=> rsp_q.exc == mmhr_pkg::EXC_ADDRESS)
        else $error("read-only write accepted");
    range_reject_a: assert property (own_take && is_write && req.count == 8'h01
        && cfg_q.remote_write_permit && req.addr == mmhr_pkg::OFS_CURRENT && req.wdata > mmhr_pkg::MAX_CURRENT
        |=> rsp_q.exc == mmhr_pkg::EXC_VALUE && $stable(current_out_q))
        else $error("out of range current accepted");

    read_seen_c: cover property (own_take && is_read ##1 rsp_valid_q && rsp_q.exc == mmhr_pkg::EXC_NONE);
    write_seen_c: cover property (own_take && is_write ##1 rsp_valid_q && rsp_q.exc == mmhr_pkg::EXC_NONE);
    bcast_seen_c: cover property (take && req.station == mmhr_pkg::BROADCAST && is_write);
    reject_seen_c: cover property (rsp_valid_q && rsp_q.exc == mmhr_pkg::EXC_VALUE);
    deny_seen_c: cover property (rsp_valid_q && rsp_q.exc == mmhr_pkg::EXC_FUNCTION);

endmodule

// *** bench/mmhr_master.sv ***
`timescale 1ns/1ps
module mmhr_master (
    // clock
    input  wire logic                clk,
    // request side
    output mmhr_pkg::mmhr_req_s      req,
    output logic                     req_valid,
    input  wire logic                req_ready_q,
    // answer side
    input  wire logic                rsp_valid_q,
    input  wire mmhr_pkg::mmhr_rsp_s rsp_q
);
    initial req_valid = 1'b0;
    initial req = '0;
    // gap idles the master, so it is slow as well as prompt
    task automatic xfer(input logic [7:0] st, fn, cnt, input logic [15:0] a, d, input int gap,
                        output mmhr_pkg::mmhr_rsp_s r, output logic got);
        repeat (gap) @(posedge clk) #1;
        while (req_ready_q !== 1'b1) @(posedge clk) #1;
        req = '{st, fn, cnt, a, d};
        req_valid = 1'b1;
        @(posedge clk) #1;
        req_valid = 1'b0;
        // a released bus must not keep showing the old request
        req = ~req;
        got = rsp_valid_q;
        r = rsp_q;
    endtask
endmodule

// *** bench/meter_modbus_holding_registers_test.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; $display("unexpected %0t: %h not %h", $time, a, b); end end
module meter_modbus_holding_registers_test;
    logic                clk, resetn, req_valid, req_ready_q, rsp_valid_q, got;
    logic                meas_over, meas_under, alarm_led, panel_permit_set, panel_permit_clr;
    logic [15:0]         meas_value, peak_value, current_out_q;
    logic [3:0]          relays_q;
    logic [7:0]          own;
    mmhr_pkg::mmhr_req_s req;
    mmhr_pkg::mmhr_rsp_s rsp_q, r;
    mmhr_pkg::mmhr_cfg_s cfg_q;
    int                  fail_count, n_tests;
    logic [15:0]         ta [9] = '{16'h0003, 16'h0005, 16'h0010, 16'h0011, 16'h0012, 16'h0016, 16'h0017,
                                    16'h0022, 16'h0024};
    logic [15:0]         tm [9] = '{16'h0003, 16'h1800, 16'h0005, 16'h0003, 16'h0005, 16'h03e7, 16'h00c7,
                                    16'h0007, 16'h000f};
    logic [15:0]         ro [4] = '{16'h0001, 16'h0002, 16'h0006, 16'h0021};

    // arbitrary identification value
    mmhr_bank #(.IDENT_CODE(16'h3c3c)) mmhr_bank_i (.clk, .resetn, .req_valid, .req, .req_ready_q, .rsp_valid_q,
        .rsp_q, .meas_value, .meas_over, .meas_under, .peak_value, .alarm_led, .panel_permit_set,
        .panel_permit_clr, .relays_q, .current_out_q, .cfg_q);
    mmhr_master mmhr_master_i (.clk, .req, .req_valid, .req_ready_q, .rsp_valid_q, .rsp_q);

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic give_verdict;
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic acc(input logic [7:0] st, fn, cnt, input logic [15:0] a, d, input logic [7:0] exc,
                       input logic [15:0] exp);
        mmhr_master_i.xfer(st, fn, cnt, a, d, n_tests % 3, r, got);
        `CHK(got, 1'b1)
        `CHK(r.silent, st != own)
        if (st == own) `CHK(r.exc, exc)
        if (st == own && exc == 8'h00) `CHK(r.rdata, exp)
    endtask
    task automatic rd(input logic [15:0] a, exp);
        acc(own, 8'h03, 8'h01, a, 16'h0000, 8'h00, exp);
    endtask
    task automatic wr(input logic [15:0] a, d, input logic [7:0] exc);
        acc(own, 8'h06, 8'h01, a, d, exc, d);
    endtask
    task automatic pulse(input logic s, c);
        panel_permit_set = s;
        panel_permit_clr = c;
        @(posedge clk) #1;
        panel_permit_set = 1'b0;
        panel_permit_clr = 1'b0;
    endtask

    initial
    begin
        repeat (3000) @(posedge clk);
        fail_count++;
        give_verdict();
    end

    initial
    begin
        fail_count = 0;
        n_tests = 0;
        own = 8'h01;
        meas_value = 16'h0000;
        peak_value = 16'h0000;
        {meas_over, meas_under, alarm_led, panel_permit_set, panel_permit_clr} = 5'h00;
        resetn = 1'b0;
        repeat (5) @(posedge clk);
        #1 resetn = 1'b1;
        rd(16'h0020, 16'h0001);
        rd(16'h0022, 16'h0003);
        rd(16'h0023, 16'h0001);
        rd(16'h0021, 16'h3c3c);
        // signed extremes travel as two's complement
        meas_value = 16'hfc19;
        peak_value = 16'h270f;
        {meas_over, meas_under} = 2'b11;
        rd(16'h0001, 16'hfc19);
        rd(16'h0006, 16'h270f);
        rd(16'h0002, 16'h00a0);
        meas_over = 1'b0;
        rd(16'h0002, 16'h0060);
        meas_under = 1'b0;
        rd(16'h0002, 16'h0000);
        for (int i = 0; i < 9; i++)
        begin
            wr(ta[i], tm[i], 8'h00);
            wr(ta[i], tm[i] + 16'h0001, 8'h03);
            rd(ta[i], tm[i]);
        end
        `CHK(current_out_q, 16'h1800)
        for (int i = 0; i < 4; i++)
            wr(ro[i], 16'h0000, 8'h02);
        wr(16'h0013, 16'h0002, 8'h00);
        rd(16'h0003, 16'h0002);
        `CHK(cfg_q.decimal_point, 2'h2)
        alarm_led = 1'b1;
        wr(16'h0004, 16'hffff, 8'h00);
        `CHK(relays_q, 4'hf)
        rd(16'h0004, 16'h001f);
        wr(16'h0004, 16'h0005, 8'h00);
        `CHK(relays_q, 4'h5)
        wr(16'h0014, 16'hfc19, 8'h00);
        wr(16'h0014, 16'hfc18, 8'h03);
        wr(16'h0015, 16'h2710, 8'h03);
        rd(16'h0014, 16'hfc19);
        acc(own, 8'h03, 8'h01, 16'h0007, 16'h0000, 8'h02, 16'h0000);
        acc(own, 8'h05, 8'h01, 16'h0003, 16'h0000, 8'h01, 16'h0000);
        acc(own, 8'h03, 8'h00, 16'h0010, 16'h0000, 8'h03, 16'h0000);
        acc(own, 8'h03, 8'h11, 16'h0010, 16'h0000, 8'h03, 16'h0000);
        acc(own, 8'h03, 8'h10, 16'h0010, 16'h0000, 8'h00, 16'h0005);
        acc(own, 8'h10, 8'h10, 16'h0012, 16'h0001, 8'h00, 16'h0001);
        acc(own, 8'h10, 8'h11, 16'h0012, 16'h0002, 8'h03, 16'h0000);
        acc(8'h00, 8'h06, 8'h01, 16'h0012, 16'h0002, 8'h00, 16'h0000);
        acc(8'h05, 8'h06, 8'h01, 16'h0012, 16'h0004, 8'h00, 16'h0000);
        rd(16'h0012, 16'h0002);
        wr(16'h0023, 16'h0000, 8'h00);
        wr(16'h0012, 16'h0003, 8'h01);
        pulse(1'b1, 1'b0);
        wr(16'h0012, 16'h0003, 8'h00);
        pulse(1'b0, 1'b1);
        wr(16'h0012, 16'h0004, 8'h01);
        pulse(1'b1, 1'b1);
        wr(16'h0012, 16'h0004, 8'h00);
        `CHK(cfg_q.filter_rate, 3'h4)
        wr(16'h0020, 16'h00c8, 8'h03);
        wr(16'h0020, 16'h0007, 8'h00);
        own = 8'h07;
        rd(16'h0020, 16'h0007);
        acc(8'h01, 8'h03, 8'h01, 16'h0012, 16'h0000, 8'h00, 16'h0000);
        // a reset in mid-run must bring back the start-up settings
        resetn = 1'b0;
        @(posedge clk) #1;
        resetn = 1'b1;
        own = 8'h01;
        `CHK(relays_q, 4'h0)
        `CHK(current_out_q, 16'h0000)
        rd(16'h0020, 16'h0001);
        rd(16'h0023, 16'h0001);
        give_verdict();
    end
endmodule
